// file: sbc_watchdog_supervisor_tb.sv
// Self-checking testbench of the supervision watchdog.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module sbc_watchdog_supervisor_tb;
  import swd_pkg::*;
  logic        mclk, rst_b, sclk, chip_select_n, sdi, dev_mode_pin, can_wake;
  logic        reset_output_n, restart_req, failsafe_req, normal_req;
  logic        wake_irq, rxd_pull_low, spi_error, saw_err, saw_low, saw_rst;
  logic        saw_fs, saw_nrm;
  logic [1:0]  fail_config, fail_count_field;
  swd_mode_t   sbc_mode;
  swd_status_t st;
  int          failures, checks, cyc;
  swd_host host (.sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi));
  swd_watchdog #(.CYC_PER_MS(20)) dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk),
    .chip_select_n(chip_select_n), .sdi(sdi), .sbc_mode(sbc_mode),
    .fail_config(fail_config), .dev_mode_pin(dev_mode_pin), .can_wake(can_wake),
    .reset_output_n(reset_output_n), .restart_req(restart_req),
    .failsafe_req(failsafe_req), .normal_req(normal_req), .wake_irq(wake_irq),
    .rxd_pull_low(rxd_pull_low), .spi_error(spi_error),
    .fail_count_field(fail_count_field), .watchdog_status(st));
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (spi_error === 1'b1) saw_err = 1'b1;
    if (reset_output_n === 1'b0) saw_low = 1'b1;
    if (restart_req === 1'b1) saw_rst = 1'b1;
    if (failsafe_req === 1'b1) saw_fs = 1'b1;
    if (normal_req === 1'b1) saw_nrm = 1'b1;
    if (cyc == 40000) begin
      failures++;
      stop_test();
    end
  end
  task automatic tick(input int k = 1);
    repeat (k) @(posedge mclk);
    #2;
  endtask : tick
  function automatic logic [15:0] ctrl(input logic [6:0] d);
    return {1'b1, ADDR_WDOG_CTRL, ^d, d};
  endfunction : ctrl
  // Waits for a watchdog reset, then measures how long it is held.
  task automatic ride_reset(output int dly, output int len);
    dly = 0;
    len = 0;
    while (reset_output_n !== 1'b0 && dly < 5000) begin tick(); dly++; end
    while (reset_output_n === 1'b0 && len < 500) begin tick(); len++; end
    tick(2);
  endtask : ride_reset
  task automatic t_reset();
    `CHK("state", ST_LONG, st.state)
    `CHK("type", 1'b0, st.watchdog_type_select)
    `CHK("bus_wake", 1'b1, st.start_on_bus_wake)
    `CHK("rst_out", 1'b1, reset_output_n)
    $display("reset test done");
  endtask : t_reset
  task automatic t_parity();
    saw_err = 1'b0;
    // Reserved bit set but left out of the checksum, so parity is odd.
    host.send({1'b1, ADDR_WDOG_CTRL, 8'h08}, 16);
    tick(70);
    `CHK("spi_err", 1'b1, saw_err)
    saw_err = 1'b0;
    host.send(ctrl(7'h00), 8);
    tick(4);
    `CHK("short", 1'b1, saw_err)
    `CHK("ignored", ST_LONG, st.state)
    $display("parity test done");
  endtask : t_parity
  task automatic t_timeout();
    int d, l;
    saw_rst = 1'b0;
    host.send(ctrl(7'h00), 16);
    tick(60);
    `CHK("run", ST_RUN, st.state)
    `CHK("period", 3'h0, st.period_select_field)
    ride_reset(d, l);
    `CHK("expiry", 1'b1, d >= 185 && d <= 205)
    `CHK("hold", RST_HOLD_CYC, l)
    `CHK("restart", 1'b1, saw_rst)
    `CHK("fail1", 2'h1, fail_count_field)
    `CHK("long", ST_LONG, st.state)
    $display("timeout test done");
  endtask : t_timeout
  task automatic t_window();
    int d, l;
    host.send(ctrl(7'h20), 16);
    tick(60);
    `CHK("cleared", 2'h0, fail_count_field)
    `CHK("window", 1'b1, st.watchdog_type_select)
    host.send(ctrl(7'h20), 16);
    ride_reset(d, l);
    `CHK("closed", 1'b1, d < 100)
    `CHK("fail_w", 2'h1, fail_count_field)
    for (int i = 0; i < 2; i++) begin
      ride_reset(d, l);
      `CHK("long_exp", 1'b1, d >= 3990 && d <= 4010)
      `CHK("sat", 2'h2, fail_count_field)
    end
    $display("window test done");
  endtask : t_window
  // The second trigger lands at about nine tenths of the period, inside the open window.
  task automatic t_stop();
    host.send(ctrl(7'h21), 16);
    tick(309);
    saw_low = 1'b0;
    host.send(ctrl(7'h61), 16);
    tick(60);
    `CHK("open_trig", ST_RUN, st.state)
    `CHK("no_fail", 1'b0, saw_low)
    `CHK("stage_b", 1'b1, st.stop_disable_stage_b)
    host.send({1'b1, ADDR_WAKE_CTRL, 8'h84}, 16);
    tick(60);
    `CHK("stage_a", 1'b1, st.stop_disable_stage_a)
    sbc_mode = MODE_STOP;
    tick(3);
    `CHK("stop_off", ST_OFF, st.state)
    can_wake = 1'b1;
    tick();
    can_wake = 1'b0;
    `CHK("wake_irq", 1'b1, wake_irq)
    `CHK("rxd_low", 1'b1, rxd_pull_low)
    tick();
    `CHK("wake_long", ST_LONG, st.state)
    `CHK("stage_a_clr", 1'b0, st.stop_disable_stage_a)
    `CHK("stage_b_clr", 1'b0, st.stop_disable_stage_b)
    `CHK("irq_pulse", 1'b0, wake_irq)
    sbc_mode = MODE_NORMAL;
    tick(2);
    `CHK("rxd_free", 1'b0, rxd_pull_low)
    $display("stop mode test done");
  endtask : t_stop
  task automatic t_fsafe();
    int d, l;
    fail_config = FAIL_CFG2;
    saw_fs = 1'b0;
    saw_nrm = 1'b0;
    saw_rst = 1'b0;
    host.send(ctrl(7'h20), 16);
    tick(60);
    host.send(ctrl(7'h20), 16);
    ride_reset(d, l);
    `CHK("fsafe", 1'b1, saw_fs)
    `CHK("no_restart", 1'b0, saw_rst)
    `CHK("normal", 1'b1, saw_nrm)
    `CHK("hold_fs", RST_HOLD_CYC, l)
    `CHK("fail_c2", 2'h1, fail_count_field)
    ride_reset(d, l);
    `CHK("sat_c2", SAT_CFG2, fail_count_field)
    sbc_mode = MODE_SLEEP;
    tick(3);
    `CHK("sleep_off", ST_OFF, st.state)
    `CHK("sleep_clr", 2'h0, fail_count_field)
    sbc_mode = MODE_NORMAL;
    tick(3);
    `CHK("norm_long", ST_LONG, st.state)
    fail_config = 2'h0;
    $display("fail-safe test done");
  endtask : t_fsafe
  task automatic t_dev();
    dev_mode_pin = 1'b1;
    tick(4);
    saw_low = 1'b0;
    tick(4400);
    `CHK("dev", 1'b0, saw_low)
    $display("development test done");
  endtask : t_dev
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    rst_b = 1'b0;
    sbc_mode = MODE_NORMAL;
    fail_config = 2'h0;
    dev_mode_pin = 1'b0;
    can_wake = 1'b0;
    tick(8);
    rst_b = 1'b1;
    tick(3);
    t_reset();
    t_parity();
    t_timeout();
    t_window();
    t_stop();
    t_fsafe();
    t_dev();
    stop_test();
  end
endmodule : sbc_watchdog_supervisor_tb

// file: swd_host.sv
// Host model that serves the watchdog over the serial link.
`timescale 1ns/1ps
module swd_host (
  output logic sclk,
  output logic chip_select_n,
  output logic sdi
);
  localparam realtime HALF = 62.5;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end
  // Shifts MSB first; the link clock stands still between frames.
  task automatic send(input logic [15:0] frame, input int nbits);
    chip_select_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi = frame[i];
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
    #(2 * HALF) chip_select_n = 1'b1;
    // A released data line holds no value, so show the inverse of the last bit.
    sdi = ~sdi;
    #400;
  endtask : send
endmodule : swd_host

// file: swd_pkg.sv
// Package with the constants, types and frame layout of the supervision watchdog.
package swd_pkg;

  // Timing base of the system clock and the delays derived from it.
  localparam int unsigned MCLK_NS         = 32'h0000_0032;
  localparam int unsigned NS_PER_MS       = 32'h000F_4240;
  localparam int unsigned CYC_PER_MS_DEF  = NS_PER_MS / MCLK_NS;
  localparam int unsigned TRIG_DELAY_NS   = 32'h0000_0BB8;
  localparam logic [6:0]  TRIG_DELAY_CYC  = 7'((TRIG_DELAY_NS + MCLK_NS - 1) / MCLK_NS);
  localparam int unsigned RST_HOLD_NS     = 32'h0000_2710;
  localparam logic [11:0] RST_HOLD_CYC    = 12'(RST_HOLD_NS / MCLK_NS);

  // Window lengths in milliseconds, indexed by the period select field.
  localparam logic [13:0] LONG_OPEN_WINDOW_TIME_MS = 14'h00C8;
  localparam logic [7:0][13:0] PERIOD_MS = {14'h2710, 14'h03E8, 14'h01F4, 14'h00C8,
                                            14'h0064, 14'h0032, 14'h0014, 14'h000A};
  localparam logic [7:0][13:0] CLOSED_MS = {14'h1770, 14'h0258, 14'h012C, 14'h0078,
                                            14'h003C, 14'h001E, 14'h000C, 14'h0006};

  // Serial frame and register addresses.
  localparam logic [4:0] FRAME_BITS     = 5'h10;
  localparam logic [6:0] ADDR_WDOG_CTRL = 7'h15;
  localparam logic [6:0] ADDR_WAKE_CTRL = 7'h06;

  // Fail counter limits; fail_config 2'h1 stands for configuration 2.
  localparam logic [1:0] FAIL_CFG2  = 2'h1;
  localparam logic [1:0] FAIL_CFG4  = 2'h3;
  localparam logic [1:0] SAT_CFG2   = 2'h1;
  localparam logic [1:0] SAT_OTHER  = 2'h2;
  localparam logic       BUS_WAKE_RST = 1'h1;

  typedef enum logic [2:0] {
    MODE_INIT     = 3'b000,
    MODE_NORMAL   = 3'b001,
    MODE_STOP     = 3'b010,
    MODE_SLEEP    = 3'b011,
    MODE_RESTART  = 3'b100,
    MODE_FAILSAFE = 3'b101
  } swd_mode_t;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_LONG = 2'b01,
    ST_RUN  = 2'b10,
    ST_HOLD = 2'b11
  } swd_state_t;

  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } swd_frame_t;

  typedef struct packed {
    logic       checksum;
    logic       stop_disable_stage_b;
    logic       watchdog_type_select;
    logic       spare;
    logic       reserved;
    logic [2:0] period_select_field;
  } swd_wdog_ctrl_t;

  typedef struct packed {
    logic       start_on_bus_wake;
    logic [3:0] spare_hi;
    logic       stop_disable_stage_a;
    logic [1:0] spare_lo;
  } swd_wake_ctrl_t;

  typedef struct packed {
    swd_state_t state;
    logic       watchdog_type_select;
    logic [2:0] period_select_field;
    logic       stop_disable_stage_a;
    logic       stop_disable_stage_b;
    logic       start_on_bus_wake;
  } swd_status_t;

endpackage : swd_pkg

// file: swd_watchdog.sv
// Supervision watchdog with its serial command receiver and stop-mode disable sequence.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Type select, time-out default, programmable in Normal only.
// - After reset release start long open window.
// - Off in Sleep/Restart; long window entering Normal.
// - Control write restarts timer and counts as trigger.
// - Trigger acts 3000 ns (60 system clock cycles) after select rises.
// - Long open window 200 ms, triggers always accepted.
// - Eight periods, 10 ms to 10000 ms.
// - Failure: reset, restart/fail-safe, count; then long window.
// - Development mode disables watchdog resets.
// - Closed-window trigger or expiry increments fail count.
// - Fail count saturates at 01 or 10.
// - Fail count clears on good trigger, Sleep, Stop disable or Fail-safe not caused by the watchdog.
// - Time-out mode: trigger restarts period, expiry fails.
// - Window mode: 60 percent closed, then open window.
// - Window mode: closed trigger or expiry fails.
// - Even parity on data byte, else ignored, error.
// - Reserved bit value counts in parity.
// - Two-stage stop disable; sequence error clears stage b.
// - Stop trigger or Normal return re-enables, clears stages.
// - Stage a clears on restart, needs stage b.
// - Bus wake in Stop starts watchdog, interrupt, receive low.
////////////////////////////////////////////////////////////////////////////////////////////////////
module swd_watchdog
  import swd_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        chip_select_n,
  input  wire logic        sdi,
  input  wire swd_mode_t   sbc_mode,
  input  wire logic [1:0]  fail_config,
  input  wire logic        dev_mode_pin,
  input  wire logic        can_wake,
  output logic             reset_output_n,
  output logic             restart_req,
  output logic             failsafe_req,
  output logic             normal_req,
  output logic             wake_irq,
  output logic             rxd_pull_low,
  output logic             spi_error,
  output logic [1:0]       fail_count_field,
  output swd_status_t      watchdog_status
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Serial link domain: bits are shifted on the rising edge of sclk while select is low.

  logic [4:0]  bit_cnt;
  logic [15:0] shift;
  swd_frame_t  frame_hold;
  logic        frame_tgl;

  // The link clock stops between frames, so select itself clears the bit counter.
  wire link_clr   = chip_select_n | ~rst_b;
  wire frame_done = (bit_cnt == FRAME_BITS - 5'h01);

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt <= 5'h00;
      shift   <= 16'h0000;
    end else begin
      bit_cnt <= (bit_cnt == FRAME_BITS) ? bit_cnt : bit_cnt + 5'h01;
      shift   <= {shift[14:0], sdi};
    end
  end

  // Only the first sixteen bits of a frame are kept; later bits are dropped.
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      frame_hold <= '0;
      frame_tgl  <= 1'b0;
    end else if (frame_done) begin
      frame_hold <= swd_frame_t'({shift[14:0], sdi});
      frame_tgl  <= ~frame_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock domain.

  logic cs_s1, cs_s2, cs_s3;
  logic tgl_s1, tgl_s2, tgl_seen;
  logic dev_s1, dev_s2;

  wire cs_rise   = cs_s2 & ~cs_s3;
  wire frame_new = tgl_s2 ^ tgl_seen;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1    <= 1'b1;
      cs_s2    <= 1'b1;
      cs_s3    <= 1'b1;
      tgl_s1   <= 1'b0;
      tgl_s2   <= 1'b0;
      tgl_seen <= 1'b0;
      dev_s1   <= 1'b0;
      dev_s2   <= 1'b0;
    end else begin
      cs_s1    <= chip_select_n;
      cs_s2    <= cs_s1;
      cs_s3    <= cs_s2;
      tgl_s1   <= frame_tgl;
      tgl_s2   <= tgl_s1;
      tgl_seen <= cs_rise ? tgl_s2 : tgl_seen;
      dev_s1   <= dev_mode_pin;
      dev_s2   <= dev_s1;
    end
  end

  // The frame word has been still for several system clock cycles when select is seen high,
  // so it is sampled directly; a later frame before execution replaces the pending one.
  swd_frame_t cmd;
  logic [6:0] dly_cnt;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd     <= '0;
      dly_cnt <= 7'h00;
    end else if (cs_rise && frame_new) begin
      cmd     <= frame_hold;
      dly_cnt <= TRIG_DELAY_CYC;
    end else if (dly_cnt != 7'h00) begin
      dly_cnt <= dly_cnt - 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Command decode.

  wire            cmd_exec   = (dly_cnt == 7'h01);
  wire            short_frm  = cs_rise & ~frame_new;
  swd_wdog_ctrl_t wd_data;
  swd_wake_ctrl_t wk_data;
  assign wd_data = swd_wdog_ctrl_t'(cmd.data);
  assign wk_data = swd_wake_ctrl_t'(cmd.data);

  wire in_normal = (sbc_mode == MODE_NORMAL);
  wire in_stop   = (sbc_mode == MODE_STOP);
  wire wd_write  = cmd_exec & cmd.write & (cmd.addr == ADDR_WDOG_CTRL);
  wire wk_write  = cmd_exec & cmd.write & (cmd.addr == ADDR_WAKE_CTRL) & in_normal;
  wire parity_ok = ~^cmd.data;
  wire wd_trig   = wd_write & parity_ok;
  wire par_err   = wd_write & ~parity_ok;
  wire cfg_load  = wd_trig & in_normal;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration and stop-mode disable sequence.

  logic       watchdog_type_select;
  logic [2:0] period_select_field;
  logic       stop_disable_stage_a;
  logic       stop_disable_stage_b;
  logic       start_on_bus_wake;
  swd_mode_t  prev_mode;
  swd_state_t state;

  wire wd_disabled = in_stop & stop_disable_stage_a & stop_disable_stage_b;
  wire stop_trig   = wd_trig & in_stop;
  wire bus_wake_go = in_stop & wd_disabled & start_on_bus_wake & can_wake;
  wire enter_norm  = in_normal & (prev_mode != MODE_NORMAL);
  wire rearm_stage = stop_trig | bus_wake_go | (enter_norm & (prev_mode == MODE_STOP));
  wire seq_start   = cfg_load & wd_data.stop_disable_stage_b;
  wire seq_err     = wk_write & ~wk_data.stop_disable_stage_a & stop_disable_stage_b
                     & ~stop_disable_stage_a;
  wire stage_a_ok  = wk_write & wk_data.stop_disable_stage_a & stop_disable_stage_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_type_select <= 1'b0;
      period_select_field  <= 3'h0;
      start_on_bus_wake    <= BUS_WAKE_RST;
      prev_mode            <= MODE_INIT;
    end else begin
      prev_mode <= sbc_mode;
      if (cfg_load) begin
        watchdog_type_select <= wd_data.watchdog_type_select;
        period_select_field  <= wd_data.period_select_field;
      end
      if (wk_write) begin
        start_on_bus_wake <= wk_data.start_on_bus_wake;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stop_disable_stage_a <= 1'b0;
      stop_disable_stage_b <= 1'b0;
    end else if (rearm_stage) begin
      stop_disable_stage_a <= 1'b0;
      stop_disable_stage_b <= 1'b0;
    end else begin
      if (seq_err) begin
        stop_disable_stage_b <= 1'b0;
      end else if (cfg_load) begin
        stop_disable_stage_b <= wd_data.stop_disable_stage_b;
      end
      if (seq_start) begin
        stop_disable_stage_a <= 1'b0;
      end else if (stage_a_ok) begin
        stop_disable_stage_a <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Watchdog timer and state machine.

  logic [23:0] presc;
  logic [13:0] ms_cnt;
  logic [11:0] hold_cnt;
  logic        wd_caused;
  logic        timer_clr;
  logic        fail_evt;
  logic        good_trig;
  swd_state_t  next_state;

  wire        ms_tick   = (presc == 24'(CYC_PER_MS - 1));
  wire [13:0] run_limit = PERIOD_MS[period_select_field];
  wire [13:0] closed_ms = CLOSED_MS[period_select_field];
  wire [13:0] limit     = (state == ST_LONG) ? LONG_OPEN_WINDOW_TIME_MS : run_limit;
  wire        expire    = ms_tick & (ms_cnt == limit - 14'h0001);
  wire        in_closed = watchdog_type_select & (ms_cnt < closed_ms);
  wire        hold_done = (hold_cnt == 12'h000);
  wire        mode_off  = (sbc_mode == MODE_SLEEP) | (sbc_mode == MODE_RESTART)
                          | (sbc_mode == MODE_FAILSAFE);
  wire        wake_up   = stop_trig | bus_wake_go;
  wire        force_off = dev_s2 | mode_off | (wd_disabled & ~wake_up);
  wire [1:0]  fail_sat  = (fail_config == FAIL_CFG2) ? SAT_CFG2 : SAT_OTHER;
  wire        to_fsafe  = fail_config[0];
  wire        clear_off = (sbc_mode == MODE_SLEEP) | wd_disabled
                          | ((sbc_mode == MODE_FAILSAFE) & ~wd_caused);

  always_comb begin
    next_state = state;
    timer_clr  = 1'b0;
    fail_evt   = 1'b0;
    good_trig  = 1'b0;
    case (state)
      ST_OFF: begin
        if (wake_up || enter_norm) begin
          next_state = ST_LONG;
          timer_clr  = 1'b1;
        end
      end
      ST_LONG: begin
        if (wd_trig) begin
          next_state = ST_RUN;
          timer_clr  = 1'b1;
          good_trig  = 1'b1;
        end else if (expire) begin
          fail_evt = 1'b1;
        end
      end
      ST_RUN: begin
        if (wd_trig && in_closed) begin
          fail_evt = 1'b1;
        end else if (wd_trig) begin
          timer_clr = 1'b1;
          good_trig = 1'b1;
        end else if (expire) begin
          fail_evt = 1'b1;
        end
      end
      ST_HOLD: begin
        if (hold_done) begin
          next_state = ST_LONG;
          timer_clr  = 1'b1;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (fail_evt) begin
      next_state = ST_HOLD;
    end
    if (force_off && state != ST_HOLD) begin
      next_state = ST_OFF;
      fail_evt   = 1'b0;
      good_trig  = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state  <= ST_LONG;
      presc  <= 24'h00_0000;
      ms_cnt <= 14'h0000;
    end else begin
      state  <= next_state;
      presc  <= (timer_clr || ms_tick) ? 24'h00_0000 : presc + 24'h00_0001;
      ms_cnt <= timer_clr ? 14'h0000 : (ms_tick ? ms_cnt + 14'h0001 : ms_cnt);
    end
  end

  // A failure wins over a clear in the same cycle so that no failure goes uncounted.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fail_count_field <= 2'h0;
      wd_caused        <= 1'b0;
    end else begin
      if (fail_evt) begin
        fail_count_field <= (fail_count_field >= fail_sat) ? fail_sat
                            : fail_count_field + 2'h1;
      end else if (good_trig || clear_off) begin
        fail_count_field <= 2'h0;
      end
      if (fail_evt) begin
        wd_caused <= 1'b1;
      end else if (in_normal) begin
        wd_caused <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reset_output_n <= 1'b1;
      hold_cnt       <= 12'h000;
      restart_req    <= 1'b0;
      failsafe_req   <= 1'b0;
      normal_req     <= 1'b0;
    end else begin
      restart_req  <= fail_evt & ~to_fsafe;
      failsafe_req <= fail_evt & to_fsafe;
      normal_req   <= (state == ST_HOLD) & hold_done;
      if (fail_evt) begin
        reset_output_n <= 1'b0;
        hold_cnt       <= RST_HOLD_CYC - 12'h001;
      end else if (state == ST_HOLD) begin
        reset_output_n <= hold_done;
        hold_cnt       <= hold_done ? hold_cnt : hold_cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wake_irq        <= 1'b0;
      rxd_pull_low    <= 1'b0;
      spi_error       <= 1'b0;
      watchdog_status <= '0;
    end else begin
      wake_irq        <= bus_wake_go;
      rxd_pull_low    <= bus_wake_go | (rxd_pull_low & in_stop);
      spi_error       <= par_err | short_frm;
      watchdog_status <= '{state, watchdog_type_select, period_select_field,
                           stop_disable_stage_a, stop_disable_stage_b, start_on_bus_wake};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_fail_enter;
    fail_evt ##1 (!reset_output_n && state == ST_HOLD);
  endsequence

  sequence s_released;
    $rose(reset_output_n) && state == ST_LONG && normal_req;
  endsequence

  cfg_hold_a: assert property (!in_normal |=> $stable(watchdog_type_select)
    && $stable(period_select_field)) else $error("configuration changed outside Normal");
  release_long_a: assert property ($rose(reset_output_n) |-> s_released)
    else $error("reset release without long window");
  fail_reset_a: assert property (fail_evt |-> s_fail_enter)
    else $error("failure did not assert reset");
  sleep_off_a: assert property (sbc_mode == MODE_SLEEP && state != ST_HOLD
    |=> state == ST_OFF) else $error("watchdog active in Sleep");
  trig_delay_a: assert property (cmd_exec |-> $past(cs_rise && frame_new, 60))
    else $error("command executed at wrong delay");
  long_len_a: assert property (state == ST_LONG |-> ms_cnt < LONG_OPEN_WINDOW_TIME_MS)
    else $error("long open window overran");
  long_trig_a: assert property (state == ST_LONG && wd_trig |=> state != ST_HOLD)
    else $error("trigger in long window counted as failure");
  period_a: assert property (state == ST_RUN |-> ms_cnt < run_limit)
    else $error("period overran");
  dev_mode_a: assert property (dev_s2 |=> reset_output_n || $past(!reset_output_n))
    else $error("reset raised in development mode");
  fail_inc_a: assert property (fail_evt && fail_count_field < fail_sat
    |=> fail_count_field == $past(fail_count_field) + 2'h1) else $error("fail count not bumped");
  fail_sat_a: assert property (fail_evt && fail_count_field == fail_sat
    |=> fail_count_field == $past(fail_count_field)) else $error("fail count passed limit");
  good_clear_a: assert property (good_trig |=> fail_count_field == 2'h0)
    else $error("fail count kept after good trigger");
  closed_trig_a: assert property (state == ST_RUN && wd_trig && in_closed
    && !force_off |=> state == ST_HOLD) else $error("closed window trigger accepted");
  parity_a: assert property (wd_write && !parity_ok |-> !good_trig ##1 spi_error)
    else $error("bad checksum not refused");
  stage_a_need_a: assert property ($rose(stop_disable_stage_a)
    |-> $past(stop_disable_stage_b)) else $error("stage a set without stage b");
  bus_wake_a: assert property (bus_wake_go |=> wake_irq && rxd_pull_low
    && state == ST_LONG) else $error("bus wake did not start watchdog");

endmodule : swd_watchdog
